// *** core/pcr_defs.vh ***
`ifndef PCR_DEFS_VH
`define PCR_DEFS_VH

// Register addresses on the register access port
`define PCR_ADDR_STANDARD   16'h0D03
`define PCR_ADDR_DIRECT     16'h9800

// Field layout of the command register
`define PCR_NUM_W           10
`define PCR_NUM_MSB         9
`define PCR_DATA_W          16
`define PCR_NUM_RESET       10'h000
`define PCR_PAD_W           6

// Bit positions of the weighted number bits
`define PCR_BIT_W1          0
`define PCR_BIT_W2          1
`define PCR_BIT_W4          2
`define PCR_BIT_W8          3
`define PCR_BIT_W16         4
`define PCR_BIT_W32         5
`define PCR_BIT_W64         6
`define PCR_BIT_W128        7
`define PCR_BIT_W256        8
`define PCR_BIT_W512        9

// Press program number limit
`define PCR_PRESS_MAX       10'h03F

// Default largest position number (model and pattern dependent)
`define PCR_POS_MAX_DEFAULT 10'h3FF

`endif

// *** core/pcr_rise.v ***
`timescale 1ns/1ps
// Rising edge detector for one command bit
module pcr_rise (
  input  wire core_clk,   // System clock
  input  wire rst,        // Synchronous reset, active high
  input  wire ce,         // Clock enable
  input  wire level,      // Control bit level
  output wire rise        // One-cycle pulse on 0 to 1
);
  reg prev_q;

  // Previous level, cleared at reset so a held bit counts once
  always @(posedge core_clk) begin
    if (rst) begin
      prev_q <= 1'b0;
    end else if (ce) begin
      prev_q <= level;
    end
  end

  assign rise = ce & level & ~prev_q;
endmodule

// *** core/pcr_top.v ***
`timescale 1ns/1ps
`include "pcr_defs.vh"
// How it works
// - Bits 0 to 9 form an unsigned binary number, bit n weighing 2**n.
// - In press mode the number picks a program, at most 63.
// - A standard-address write stores; outside press mode the move waits for the start bit.
// - A direct-move-address write stores and, outside press mode, starts the move at once.
// - In press mode a rising program start bit runs the chosen program.
// - In press mode a rising home-return bit homes per the program, unless a program start rises in the same cycle.
// - Position numbers above the configured limit are refused.
module pcr_top (
  input  wire        core_clk,       // System clock, 10 MHz
  input  wire        rst,            // Synchronous reset, active high
  input  wire        ce,             // Clock enable, freezes state when low
  input  wire        press_mode,     // High for the press variant
  input  wire [9:0]  pos_limit,      // Configured largest position number
  input  wire        reg_wr,         // Register write strobe
  input  wire        reg_rd,         // Register read strobe
  input  wire [15:0] reg_addr,       // Register address
  input  wire [15:0] reg_wdata,      // Register write data
  output reg  [15:0] reg_rdata,      // Register read data
  output reg         reg_ack,        // Access accepted
  output reg         reg_err,        // Access refused
  input  wire        move_start_bit, // Start bit level
  input  wire        press_program_start_bit, // Program start level
  input  wire        program_home_return_bit, // Home-return level
  output reg  [9:0]  cmd_num,        // Latched command number
  output reg         move_go,        // Move to position, pulse
  output reg         prog_run,       // Run press program, pulse
  output reg         prog_home,      // Program home return, pulse
  output reg         cmd_refused     // Out-of-range number, pulse
);
  // Stored number and its next value
  reg  [`PCR_NUM_MSB:0]  num_q;
  reg  [`PCR_NUM_MSB:0]  num_d;

  // Next values of the registered outputs
  reg  [`PCR_DATA_W-1:0] rdata_d;
  reg                    ack_d;
  reg                    err_d;
  reg                    refused_d;
  reg  [`PCR_NUM_MSB:0]  cmd_num_d;
  reg                    move_go_d;
  reg                    prog_run_d;
  reg                    prog_home_d;

  // Edges of the three control bits
  wire                   start_rise;
  wire                   pstart_rise;
  wire                   home_rise;

  // Decoded access
  wire                   hit_std;
  wire                   hit_dir;
  wire                   hit_any;
  wire                   access;
  wire [`PCR_NUM_MSB:0]  wr_num;
  wire [`PCR_NUM_MSB:0]  limit;
  wire                   wr_ok;
  wire                   wr_bad;
  wire                   num_ok;

  // Decoded commands, highest priority first
  wire                   do_direct;
  wire                   do_move;
  wire                   do_run;
  wire                   do_home;

  // Weighted bits of the stored number
  wire                   target_bit_weight_1;
  wire                   target_bit_weight_2;
  wire                   target_bit_weight_4;
  wire                   target_bit_weight_8;
  wire                   target_bit_weight_16;
  wire                   target_bit_weight_32;
  wire                   target_bit_weight_64;
  wire                   target_bit_weight_128;
  wire                   target_bit_weight_256;
  wire                   target_bit_weight_512;
  wire [`PCR_NUM_MSB:0]  readback;

  assign target_bit_weight_1   = num_q[`PCR_BIT_W1];
  assign target_bit_weight_2   = num_q[`PCR_BIT_W2];
  assign target_bit_weight_4   = num_q[`PCR_BIT_W4];
  assign target_bit_weight_8   = num_q[`PCR_BIT_W8];
  assign target_bit_weight_16  = num_q[`PCR_BIT_W16];
  assign target_bit_weight_32  = num_q[`PCR_BIT_W32];
  assign target_bit_weight_64  = num_q[`PCR_BIT_W64];
  assign target_bit_weight_128 = num_q[`PCR_BIT_W128];
  assign target_bit_weight_256 = num_q[`PCR_BIT_W256];
  assign target_bit_weight_512 = num_q[`PCR_BIT_W512];

  // Read value rebuilt from the weighted bits, heaviest first
  assign readback = {
    target_bit_weight_512,
    target_bit_weight_256,
    target_bit_weight_128,
    target_bit_weight_64,
    target_bit_weight_32,
    target_bit_weight_16,
    target_bit_weight_8,
    target_bit_weight_4,
    target_bit_weight_2,
    target_bit_weight_1
  };

  // Edge detectors reset low, so a bit high at release counts once

  pcr_rise u_start (
    .core_clk (core_clk),
    .rst      (rst),
    .ce       (ce),
    .level    (move_start_bit),
    .rise     (start_rise)
  );
  pcr_rise u_pstart (
    .core_clk (core_clk),
    .rst      (rst),
    .ce       (ce),
    .level    (press_program_start_bit),
    .rise     (pstart_rise)
  );
  pcr_rise u_home (
    .core_clk (core_clk),
    .rst      (rst),
    .ce       (ce),
    .level    (program_home_return_bit),
    .rise     (home_rise)
  );

  // Address decode, both addresses reach the same number
  assign hit_std = (reg_addr == `PCR_ADDR_STANDARD);
  assign hit_dir = (reg_addr == `PCR_ADDR_DIRECT);
  assign hit_any = hit_std | hit_dir;
  assign access  = reg_wr | reg_rd;

  assign wr_num  = reg_wdata[`PCR_NUM_MSB:0];

  assign limit   = press_mode ? `PCR_PRESS_MAX : pos_limit;
  assign wr_ok   = (wr_num <= limit);
  assign num_ok  = (num_q <= limit);
  assign wr_bad  = reg_wr & hit_any & ~wr_ok;

  // direct write moves at once outside press mode
  assign do_direct = reg_wr & hit_dir & wr_ok & ~press_mode;
  // start edge uses the stored number
  assign do_move   = ~press_mode & start_rise & num_ok;
  assign do_run    = press_mode & pstart_rise & num_ok;
  assign do_home   = press_mode & home_rise & num_ok;

  // Next stored number
  always @* begin
    num_d = num_q;
    if (reg_wr && hit_any && wr_ok) begin
      num_d = wr_num;
    end
  end

  // Bus answer, refused writes leave the number alone
  always @* begin
    ack_d     = access & hit_any & ~wr_bad;
    err_d     = access & (~hit_any | wr_bad);
    refused_d = wr_bad;
    rdata_d   = {`PCR_DATA_W{1'b0}};
    if (reg_rd && hit_any) begin
      rdata_d = {{`PCR_PAD_W{1'b0}}, readback};
    end
  end

  // Command choice; a start in a write cycle sees the old number
  always @* begin
    cmd_num_d   = cmd_num;
    move_go_d   = 1'b0;
    prog_run_d  = 1'b0;
    prog_home_d = 1'b0;
    if (do_direct) begin
      cmd_num_d = wr_num;
      move_go_d = 1'b1;
    end else if (do_move) begin
      cmd_num_d = num_q;
      move_go_d = 1'b1;
    end else if (do_run) begin
      cmd_num_d  = num_q;
      prog_run_d = 1'b1;
    end else if (do_home) begin
      cmd_num_d   = num_q;
      prog_home_d = 1'b1;
    end
  end

  // Stored number
  always @(posedge core_clk) begin
    if (rst) begin
      num_q <= `PCR_NUM_RESET;
    end else if (ce) begin
      num_q <= num_d;
    end
  end

  // Registered bus answer, one cycle after the strobe
  always @(posedge core_clk) begin
    if (rst) begin
      reg_rdata <= {`PCR_DATA_W{1'b0}};
      reg_ack   <= 1'b0;
      reg_err   <= 1'b0;
    end else if (ce) begin
      reg_rdata <= rdata_d;
      reg_ack   <= ack_d;
      reg_err   <= err_d;
    end
  end

  // Registered command pulses and latched number
  always @(posedge core_clk) begin
    if (rst) begin
      cmd_num     <= `PCR_NUM_RESET;
      move_go     <= 1'b0;
      prog_run    <= 1'b0;
      prog_home   <= 1'b0;
      cmd_refused <= 1'b0;
    end else if (ce) begin
      cmd_num     <= cmd_num_d;
      move_go     <= move_go_d;
      prog_run    <= prog_run_d;
      prog_home   <= prog_home_d;
      cmd_refused <= refused_d;
    end
  end
endmodule

// *** sim/pcr_checker.sv ***
`timescale 1ns/1ps
// Ties move and home pulses to their requests; prog_run is checked only for press mode and a number up to 63
module pcr_checker (
  input wire        core_clk, rst, ce, press_mode, // Clock, reset, mode
  input wire        reg_wr, reg_rd, reg_ack, reg_err, // Access
  input wire [9:0]  pos_limit, cmd_num,             // Limit, number
  input wire [15:0] reg_addr, reg_wdata,            // Address, data
  input wire        move_start_bit, move_go, cmd_refused, // Move
  input wire        program_home_return_bit, prog_run, prog_home // Press
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (rst || !ce);
  wire [9:0] d = reg_wdata[9:0]; // Written number
  // Direct write within the limit
  sequence s_dir;
    reg_wr && reg_addr == 16'h9800 && !press_mode && d <= pos_limit;
  endsequence
  AST_DIR: assert property (s_dir |=> move_go && cmd_num == $past(d))
    else $error("direct write gave no move");
  AST_STD: assert property (reg_wr && reg_addr == 16'h0D03 &&
    !$rose(move_start_bit) && !$past(rst) |=> !move_go)
    else $error("standard write moved");
  AST_LIM: assert property (reg_wr && !press_mode && d > pos_limit &&
    reg_addr == 16'h9800 |=> reg_err && cmd_refused && !move_go)
    else $error("over limit accepted");
  AST_PRS: assert property (press_mode && reg_wr && d > 10'h03F &&
    reg_addr == 16'h0D03 |=> cmd_refused)
    else $error("program number over 63 accepted");
  AST_RUN: assert property (prog_run |-> $past(press_mode) &&
    cmd_num <= 10'h03F)
    else $error("bad program run");
  AST_HOME: assert property (prog_home |-> $past(press_mode) &&
    $past(program_home_return_bit))
    else $error("bad home return");
  AST_ONCE: assert property (move_start_bit && $past(move_start_bit) &&
    !reg_wr && !$past(rst) |=> !move_go)
    else $error("start acted twice");
  AST_ACK: assert property (reg_wr || reg_rd |=> reg_ack || reg_err)
    else $error("access unanswered");
endmodule
bind pcr_top pcr_checker chk_u (.*);

// *** sim/pcr_host.sv ***
`timescale 1ns/1ps
// Host master: register accesses and start bits
module pcr_host (
  input  wire        core_clk,  // Clock
  output reg         reg_wr,    // Write strobe
  output reg         reg_rd,    // Read strobe
  output reg  [15:0] reg_addr,  // Address
  output reg  [15:0] reg_wdata, // Write data
  output reg  [2:0]  bits       // Move, program, home
);
  initial {reg_wr, reg_rd, reg_addr, reg_wdata, bits} = 37'h0;
  // One access; released lines show the inverse
  task acc(input rd, input [15:0] a, input [15:0] d);
    @(posedge core_clk) #1;
    {reg_rd, reg_wr, reg_addr, reg_wdata} = {rd, !rd, a, d};
    @(posedge core_clk) #1;
    {reg_rd, reg_wr, reg_addr, reg_wdata} = {2'b00, ~a, ~d};
  endtask
  task kick(input integer i);
    @(posedge core_clk) #1 bits[i] = 1'b1;
    repeat (2) @(posedge core_clk);
    #1 bits[i] = 1'b0;
  endtask
endmodule

// *** sim/position_command_register_test.sv ***
`timescale 1ns/1ps
// Bench: driver notes results, monitor compares
module position_command_register_test;
  reg         core_clk = 1'b0, rst = 1'b1, pm = 1'b0; // Clock, reset, mode
  wire        wr, rd, ack, err, go, run, home, rf;   // Strobes, pulses
  wire [15:0] ad, wd, rdat;                           // Bus
  wire [2:0]  sb;                                     // Start bits
  wire [9:0]  num;                                    // Latched number
  reg  [32:0] q[$];                                   // Expected notes
  reg         ce_r = 1'b1;                            // Clock enable
  reg  [9:0]  lim = 10'h1F4;                          // Position limit
  integer     seed = 54741, miscompares = 0, n_compared = 0, cyc = 0, v;
  pcr_host host_u (.core_clk(core_clk), .reg_wr(wr), .reg_rd(rd),
    .reg_addr(ad), .reg_wdata(wd), .bits(sb));
  pcr_top dut_u (.core_clk(core_clk), .rst(rst), .ce(ce_r),
    .press_mode(pm), .pos_limit(lim), .reg_wr(wr), .reg_rd(rd),
    .reg_addr(ad), .reg_wdata(wd), .reg_rdata(rdat), .reg_ack(ack),
    .reg_err(err), .move_start_bit(sb[0]),
    .press_program_start_bit(sb[1]), .program_home_return_bit(sb[2]),
    .cmd_num(num), .move_go(go), .prog_run(run), .prog_home(home),
    .cmd_refused(rf));
  // Access with its note
  task t(input r, input [15:0] a, input [9:0] d, input [5:0] f,
    input [9:0] n, input [15:0] x);
    q.push_back({r, f, n, x});
    host_u.acc(r, a, {6'h00, d});
  endtask
  // Start bit with its note
  task k(input integer i, input [5:0] f, input [9:0] n);
    q.push_back({1'b0, f, n, 16'h0000});
    host_u.kick(i);
  endtask
  task stop_test;
    miscompares = miscompares + q.size();
    $display("compared %0d miscompares %0d", n_compared, miscompares);
    if (miscompares == 0 && n_compared > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask
  // Clock
  initial forever #50 core_clk = ~core_clk;
  // Monitor and cycle ceiling
  always @(posedge core_clk) begin
    cyc = cyc + 1;
    #2;
    if ({ack, err, go, run, home, rf} !== 6'h00) begin
      n_compared = n_compared + 1;
      if (q.size() == 0 || {ack, err, go, run, home, rf, num,
          q[0][32] ? rdat : 16'h0000} !== q[0][31:0]) begin
        miscompares = miscompares + 1;
        $display("BAD %0t got %h", $time, {ack, err, go, run, home, rf});
      end
      if (q.size() != 0) q.delete(0);
    end
    if (cyc == 300) begin
      miscompares = miscompares + 1;
      stop_test;
    end
  end
  // Scenarios
  initial begin
    repeat (3) @(posedge core_clk);
    #1 rst = 1'b0;
    v = {$random(seed)} % 500;
    t(0, 16'h9800, v[9:0], 6'h28, v[9:0], 16'h0000);
    t(0, 16'h0D03, 10'h1F4, 6'h20, v[9:0], 16'h0000);
    t(1, 16'h0D03, 10'h000, 6'h20, v[9:0], 16'h01F4);
    k(0, 6'h08, 10'h1F4);
    t(0, 16'h9800, 10'h1F5, 6'h11, 10'h1F4, 16'h0000);
    t(1, 16'h1234, 10'h000, 6'h10, 10'h1F4, 16'h0000);
    lim = 10'h1F3;
    host_u.kick(0);
    lim = 10'h1F4;
    @(posedge core_clk) #1 ce_r = 1'b0;
    host_u.acc(0, 16'h9800, 16'h0005);
    ce_r = 1'b1;
    t(1, 16'h0D03, 10'h000, 6'h20, 10'h1F4, 16'h01F4);
    pm = 1'b1;
    t(0, 16'h0D03, 10'h03F, 6'h20, 10'h1F4, 16'h0000);
    host_u.kick(0);
    k(1, 6'h04, 10'h03F);
    k(2, 6'h02, 10'h03F);
    t(0, 16'h9800, 10'h010, 6'h20, 10'h03F, 16'h0000);
    k(1, 6'h04, 10'h010);
    t(0, 16'h0D03, 10'h040, 6'h11, 10'h010, 16'h0000);
    @(posedge core_clk) #1 rst = 1'b1;
    @(posedge core_clk) #1 rst = 1'b0;
    t(1, 16'h0D03, 10'h000, 6'h20, 10'h000, 16'h0000);
    repeat (3) @(posedge core_clk);
    stop_test;
  end
endmodule
